// file: design/hwb_pkg.sv
// shared constants and types for the wrap burst sequencer
package hwb_pkg;
	// burst configuration field positions and reset values
	localparam int         HYBRID_BIT_POS  = 2;
	localparam logic       HYBRID_RST      = 1'b1;
	localparam logic [1:0] BURST_LEN_RST   = 2'b11;
	// burst length encodings
	localparam logic [1:0] LEN_128         = 2'b00;
	localparam logic [1:0] LEN_64          = 2'b01;
	localparam logic [1:0] LEN_16          = 2'b10;
	localparam logic [1:0] LEN_32          = 2'b11;
	// command/address phase field positions
	localparam int         CA_W            = 48;
	localparam int         CA_TYPE_POS     = 45;
	localparam int         CA_UPPER_HI     = 44;
	localparam int         CA_UPPER_LO     = 16;
	localparam int         CA_LOWER_HI     = 2;
	localparam int         ADDR_W          = 32;
	// buffer depth
	localparam int         BUF_DEPTH       = 2;

	typedef struct packed {
		logic       hybrid_off;
		logic [1:0] len;
	} hwb_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WRAP   = 2'b01,
		ST_LINEAR = 2'b10
	} hwb_state_t;
endpackage

// file: design/hwb_sequencer.sv
// burst address sequencer with config crossing and output buffer
//
// Function
// - hybrid burst first wraps within the aligned group holding the start.
// - after one wrap, hybrid continues linearly from the next group base.
// - linear continuation runs until chip select returns high.
// - config bit 2 low selects hybrid, high selects legacy; resets high.
// - groups of 16/32/64/128 bytes span 8/16/32/64 words, self aligned.
// - legacy wrap climbs to the group top, returns to base, continues.
// - linear burst adds one per word with no boundary from start.
// - hybrid bit only applies when command burst-type bit 45 is zero.
// - length field 00=128, 01=64, 10=16, 11=32 bytes; resets to 11.
`timescale 1ns/1ns
module hwb_sequencer (
	// core clock and reset
	input  wire logic                        CORE_CLK,
	input  wire logic                        RSTN,
	// configuration write and readback, core domain
	input  wire logic                        CFG_WE,
	input  wire logic                        CFG_HYBRID_OFF,
	input  wire logic [1:0]                  CFG_BURST_LEN,
	output logic                             CFG_HYBRID_Q,
	output logic      [1:0]                  CFG_LEN_Q,
	// link side, on the bus clock
	input  wire logic                        LINK_CK,
	input  wire logic                        CS_N,
	input  wire logic                        CA_STROBE,
	input  wire logic [hwb_pkg::CA_W-1:0]    CA_WORD,
	// address stream out, on the bus clock
	output logic                             ADDR_VALID,
	input  wire logic                        ADDR_READY,
	output logic      [hwb_pkg::ADDR_W-1:0]  ADDR_WORD
);
	localparam int AW = hwb_pkg::ADDR_W;

	// word mask of a wrap group
	function automatic logic [AW-1:0] group_mask(input logic [1:0] len);
		logic [AW-1:0] m;
		m = '0;
		unique case (len)
			hwb_pkg::LEN_128: m = 32'h0000_003F;
			hwb_pkg::LEN_64:  m = 32'h0000_001F;
			hwb_pkg::LEN_16:  m = 32'h0000_0007;
			hwb_pkg::LEN_32:  m = 32'h0000_000F;
		endcase
		return m;
	endfunction

	// configuration register, core domain
	hwb_pkg::hwb_cfg_t cfg_core;
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cfg_core <= '{hybrid_off: hwb_pkg::HYBRID_RST,
			              len: hwb_pkg::BURST_LEN_RST};
		end else if (CFG_WE) begin
			cfg_core <= '{hybrid_off: CFG_HYBRID_OFF, len: CFG_BURST_LEN};
		end
	end
	assign CFG_HYBRID_Q = cfg_core.hybrid_off;
	assign CFG_LEN_Q    = cfg_core.len;

	// config crosses into the link domain; taken when stages 2 and 3 agree
	hwb_pkg::hwb_cfg_t cfg_s1, cfg_s2, cfg_s3, cfg;
	always_ff @(posedge LINK_CK or negedge RSTN) begin
		if (!RSTN) begin
			cfg_s1 <= '{hybrid_off: hwb_pkg::HYBRID_RST,
			            len: hwb_pkg::BURST_LEN_RST};
			cfg_s2 <= '{hybrid_off: hwb_pkg::HYBRID_RST,
			            len: hwb_pkg::BURST_LEN_RST};
			cfg_s3 <= '{hybrid_off: hwb_pkg::HYBRID_RST,
			            len: hwb_pkg::BURST_LEN_RST};
			cfg    <= '{hybrid_off: hwb_pkg::HYBRID_RST,
			            len: hwb_pkg::BURST_LEN_RST};
		end else begin
			cfg_s1 <= cfg_core;
			cfg_s2 <= cfg_s1;
			cfg_s3 <= cfg_s2;
			if (cfg_s2 == cfg_s3) begin
				cfg <= cfg_s3;
			end
		end
	end

	// two-entry address buffer
	logic [AW-1:0] buf_mem [hwb_pkg::BUF_DEPTH];
	logic          wr_ptr;
	logic          rd_ptr;
	logic [1:0]    buf_cnt;
	wire           in_ready = (buf_cnt != 2'(hwb_pkg::BUF_DEPTH));
	wire           pop      = ADDR_VALID && ADDR_READY;

	// sequencer state
	hwb_pkg::hwb_state_t state;
	logic [AW-1:0]       addr;
	logic [6:0]          count;
	wire  [AW-1:0]       mask      = group_mask(cfg.len);
	wire  [6:0]          last_idx  = 7'(mask);
	wire  [AW-1:0]       base      = addr & ~mask;
	wire  [AW-1:0]       wrap_next = base | ((addr + 32'h1) & mask);
	wire  [AW-1:0]       ca_start  = {CA_WORD[hwb_pkg::CA_UPPER_HI:
	                                          hwb_pkg::CA_UPPER_LO],
	                                  CA_WORD[hwb_pkg::CA_LOWER_HI:0]};
	wire                 ca_take   = CA_STROBE && !CS_N;
	wire                 ca_linear = CA_WORD[hwb_pkg::CA_TYPE_POS];
	// chip select gates activity so a stopped clock leaves nothing running
	wire                 active    = (state != hwb_pkg::ST_IDLE) && !CS_N;
	wire                 push      = active && in_ready && !ca_take;
	wire                 hyb_turn  = (state == hwb_pkg::ST_WRAP) &&
	                                 !cfg.hybrid_off && (count == last_idx);

	logic [AW-1:0]       next_addr;
	hwb_pkg::hwb_state_t next_state;
	always_comb begin
		next_addr  = addr;
		next_state = state;
		if (CS_N) begin
			next_state = hwb_pkg::ST_IDLE;
		end else if (ca_take) begin
			next_addr  = ca_start;
			next_state = ca_linear ? hwb_pkg::ST_LINEAR
			                       : hwb_pkg::ST_WRAP;
		end else if (push) begin
			unique case (state)
				hwb_pkg::ST_WRAP: begin
					if (hyb_turn) begin
						next_addr  = base + mask + 32'h1;
						next_state = hwb_pkg::ST_LINEAR;
					end else begin
						next_addr = wrap_next;
					end
				end
				hwb_pkg::ST_LINEAR: next_addr = addr + 32'h1;
				default:            next_addr = addr;
			endcase
		end
	end

	always_ff @(posedge LINK_CK or negedge RSTN) begin
		if (!RSTN) begin
			state <= hwb_pkg::ST_IDLE;
			addr  <= '0;
			count <= '0;
		end else begin
			state <= next_state;
			addr  <= next_addr;
			if (ca_take) begin
				count <= '0;
			end else if (push && state == hwb_pkg::ST_WRAP) begin
				count <= count + 7'h01;
			end
		end
	end

	always_ff @(posedge LINK_CK or negedge RSTN) begin
		if (!RSTN) begin
			wr_ptr     <= 1'b0;
			rd_ptr     <= 1'b0;
			buf_cnt    <= 2'h0;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			if (push) begin
				buf_mem[wr_ptr] <= addr;
				wr_ptr          <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			buf_cnt <= buf_cnt + 2'(push) - 2'(pop);
		end
	end
	assign ADDR_VALID = (buf_cnt != 2'h0);
	assign ADDR_WORD  = buf_mem[rd_ptr];

	property p_legacy_upper;
		@(posedge LINK_CK) disable iff (!RSTN)
		(push && state == hwb_pkg::ST_WRAP && cfg.hybrid_off && !CS_N)
		|=> ((addr & ~mask) == $past(addr & ~mask));
	endproperty
	a_legacy_upper: assert property (p_legacy_upper)
		else $error("legacy wrap changed upper address bits");

	property p_wrap_return;
		@(posedge LINK_CK) disable iff (!RSTN)
		(push && state == hwb_pkg::ST_WRAP && cfg.hybrid_off &&
		 ((addr & mask) == mask) && !CS_N)
		|=> ((addr & mask) == '0);
	endproperty
	a_wrap_return: assert property (p_wrap_return)
		else $error("legacy wrap did not return to group base");

	property p_hybrid_jump;
		@(posedge LINK_CK) disable iff (!RSTN)
		(push && hyb_turn && !CS_N)
		|=> (addr == $past(base) + $past(mask) + 32'h1) &&
		    (state == hwb_pkg::ST_LINEAR);
	endproperty
	a_hybrid_jump: assert property (p_hybrid_jump)
		else $error("hybrid burst did not move to next group base");

	property p_hybrid_wrap_len;
		@(posedge LINK_CK) disable iff (!RSTN)
		(state == hwb_pkg::ST_WRAP && !cfg.hybrid_off)
		|-> (count <= last_idx);
	endproperty
	a_hybrid_wrap_len: assert property (p_hybrid_wrap_len)
		else $error("hybrid wrap ran past one group length");

	property p_linear_step;
		@(posedge LINK_CK) disable iff (!RSTN)
		(push && state == hwb_pkg::ST_LINEAR && !CS_N)
		|=> (addr == $past(addr) + 32'h1);
	endproperty
	a_linear_step: assert property (p_linear_step)
		else $error("linear burst did not step by one word");

	property p_cs_ends;
		@(posedge LINK_CK) disable iff (!RSTN)
		CS_N |=> (state == hwb_pkg::ST_IDLE);
	endproperty
	a_cs_ends: assert property (p_cs_ends)
		else $error("burst continued after chip select high");

	property p_ca_type;
		@(posedge LINK_CK) disable iff (!RSTN)
		ca_take |=> (addr == $past(ca_start)) &&
		            (state == ($past(ca_linear) ? hwb_pkg::ST_LINEAR
		                                        : hwb_pkg::ST_WRAP));
	endproperty
	a_ca_type: assert property (p_ca_type)
		else $error("burst type or start address not taken");

	property p_hybrid_sel;
		@(posedge LINK_CK) disable iff (!RSTN)
		(push && state == hwb_pkg::ST_WRAP && !CS_N && !hyb_turn)
		|=> (state == hwb_pkg::ST_WRAP);
	endproperty
	a_hybrid_sel: assert property (p_hybrid_sel)
		else $error("wrap left early");

	property p_full_stall;
		@(posedge LINK_CK) disable iff (!RSTN)
		(buf_cnt == 2'h2) |-> !push ##1 (buf_cnt != 2'h3);
	endproperty
	a_full_stall: assert property (p_full_stall)
		else $error("buffer overfilled");
endmodule

// file: verification/hwb_host.sv
// host controller model framing bursts on the link clock
`timescale 1ns/1ns
module hwb_host (
	// frame request from the bench
	input  wire logic                     lck,
	input  wire logic                     go,
	input  wire logic [hwb_pkg::CA_W-1:0] ca_in,
	// burst bus toward the device
	output logic                          cs_n,
	output logic                          strobe,
	output logic      [hwb_pkg::CA_W-1:0] ca_word
);
	initial begin
		cs_n = 1'b1;
		strobe = 1'b0;
		ca_word = '0;
	end
	always @(negedge lck) begin
		strobe <= go && cs_n;
		// frame ends only when the bench drops go
		cs_n <= !go;
		// released lines toggle so a stale word never passes
		ca_word <= (go && cs_n) ? ca_in : ~ca_word;
	end
endmodule

// file: verification/tb_top.sv
// self-checking bench for the wrap burst sequencer
`timescale 1ns/1ns
module tb_top;
	logic        clk, lck, rstn, we, hoff, go, cs_n, stb, vld, rdy, hq;
	logic [1:0]  blen, lq;
	logic [47:0] ca_in, ca;
	logic [31:0] aw, r, s, q[$];
	logic [1:0]  lens[4];
	int          n_fail, checks, taken, n;

	hwb_sequencer dut (.CORE_CLK(clk), .RSTN(rstn), .CFG_WE(we),
		.CFG_HYBRID_OFF(hoff), .CFG_BURST_LEN(blen), .CFG_HYBRID_Q(hq),
		.CFG_LEN_Q(lq), .LINK_CK(lck), .CS_N(cs_n), .CA_STROBE(stb),
		.CA_WORD(ca), .ADDR_VALID(vld), .ADDR_READY(rdy), .ADDR_WORD(aw));
	hwb_host host (.lck(lck), .go(go), .ca_in(ca_in), .cs_n(cs_n),
		.strobe(stb), .ca_word(ca));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		lck = 1'b0;
		#3;
		forever #16 lck = ~lck;
	end

	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// m: 0 hybrid, 1 legacy wrap, 2 linear; w group size in words
	function automatic logic [31:0] ex(input logic [31:0] s, w, i,
		input int m);
		// linear counts on from the start word itself, not the group base
		if (m == 2)
			return s + i;
		if (m == 0 && i >= w)
			return (s & ~(w - 32'h1)) + i;
		return (s & ~(w - 32'h1)) | ((s + i) & (w - 32'h1));
	endfunction

	task automatic chk(input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// receiver stalls about one word in four
	always @(negedge lck) begin
		r <= nx(r);
		rdy <= r[0] | r[1];
	end

	always @(posedge lck) if (vld && rdy && q.size() > 0) begin
		chk(aw, q.pop_front());
		taken++;
	end

	initial begin
		r = 32'hAE6C;
		lens = '{hwb_pkg::LEN_16, hwb_pkg::LEN_32, hwb_pkg::LEN_64,
			hwb_pkg::LEN_128};
		{rstn, we, hoff, blen, go, ca_in, rdy} = '0;
		repeat (20) @(posedge clk);
		chk(hq, 1'b1);
		chk(lq, 2'b11);
		chk(vld, 1'b0);
		@(negedge clk) rstn = 1'b1;
		for (int m = 0; m < 3; m++) for (int k = 0; k < 4; k++) begin
			@(negedge clk);
			{we, hoff, blen} = {1'b1, m[0], lens[k]};
			@(negedge clk) we = 1'b0;
			chk(hq, m[0]);
			chk(lq, lens[k]);
			repeat (8) @(posedge lck);
			// low start keeps every burst inside one die
			s = {16'h0, r[15:0]};
			n = 2 * (8 << k) + 3;
			for (int i = 0; i < n + 4; i++)
				q.push_back(ex(s, 8 << k, i, m));
			taken = 0;
			// linear bursts keep the hybrid bit low: it must be ignored
			@(posedge lck);
			ca_in = {2'b0, m == 2, s[31:3], 13'h0, s[2:0]};
			go = 1'b1;
			for (int t = 0; t < 2000 && taken < n; t++) @(posedge lck);
			// a stream that stopped short must not pass quietly
			chk(taken >= n, 1'b1);
			@(posedge lck) go = 1'b0;
			repeat (20) @(posedge lck);
			q.delete();
			$display("burst mode %0d size %0d done", m, k);
		end
		results();
	end

	initial begin
		#200000;
		n_fail++;
		results();
	end
endmodule
